// ==== flash_seq_pkg.sv ====
/*
  flash_seq_pkg: shared constants and types for the flash command sequencer
  (device end) and its bus master (host end).
  Assumes a single 50 MHz clock, clk_sys, shared by both ends.
*/
package flash_seq_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CMD_ADDR_W = 12;
  localparam int N_MAIN = 8;
  localparam int N_SEC = 4;
  localparam int N_SECT = 12;
  localparam int CNT_W = 24;

  // unlock addresses, low twelve bits only
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'hAAA;

  // command bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;

  // identifier-mode read offsets (A1:A0) and answers
  localparam logic [1:0] ID_OFFSET = 2'h1;
  localparam logic [1:0] PROT_OFFSET = 2'h2;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  // identifier value is arbitrary
  localparam logic [7:0] MAIN_ID_DEFAULT = 8'h5A;

  // timing
  localparam int ERASE_WIN_US = 80;
  localparam int ERASE_WIN_CYC = ERASE_WIN_US * 1000 / CLK_PERIOD_NS;
  localparam int CMD_GAP_US = 80;
  localparam int CMD_GAP_CYC = CMD_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_TIME_US = 10;
  localparam int PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_TIME_US = 1000;
  localparam int ERASE_CYC_DEFAULT = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int HOST_SETUP_CYC = 1;
  localparam int HOST_STROBE_CYC = 3;

  typedef enum logic [3:0] {
    D_READ = 4'h0,
    D_U1 = 4'h1,
    D_U2 = 4'h3,
    D_PROG = 4'h2,
    D_E3 = 4'h6,
    D_E4 = 4'h7,
    D_E5 = 4'h5,
    D_ID = 4'h4,
    D_BYP = 4'hC,
    D_BYP_PROG = 4'hD,
    D_BYP_EXIT = 4'hF
  } dec_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_WIN = 2'h1,
    E_RUN = 2'h3,
    E_SUSP = 2'h2
  } erase_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SETUP = 2'h1,
    H_STROBE = 2'h3,
    H_HOLD = 2'h2
  } host_state_t;

endpackage

// ==== flash_bus_if.sv ====
/*
  flash_bus_if: parallel microcontroller bus between host end and flash
  sequencer. Assumes both ends run on the same clk_sys; data is split into
  separate write and read paths, so no wire needs resolving.
*/
`timescale 1ns/10ps
interface flash_bus_if;
  import flash_seq_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic control_pin_zero_n;
  logic rd_n;
  logic [N_MAIN-1:0] main_sector_select;
  logic [N_SEC-1:0] secondary_sector_select;
  logic ready_busy_pin;

  modport host_end (
    output addr, wdata, control_pin_zero_n, rd_n, main_sector_select,
    output secondary_sector_select,
    input rdata, ready_busy_pin
  );
  modport device_end (
    input addr, wdata, control_pin_zero_n, rd_n, main_sector_select,
    input secondary_sector_select,
    output rdata, ready_busy_pin
  );
endinterface

// ==== flash_cmd_host.sv ====
/*
  flash_cmd_host: bus master that turns single user requests into one
  read or write cycle on the flash bus. Assumes the user issues command
  sequences in the documented order and spacing; it does not build them.
*/
`timescale 1ns/10ps
module flash_cmd_host import flash_seq_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  flash_bus_if.host_end bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [N_SECT-1:0] req_sel,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_data,
  output logic dev_ready
);
  host_state_t st_reg;
  logic [3:0] cnt_reg;
  logic write_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [N_SECT-1:0] sel_reg;
  logic strobe_reg;

  assign req_ready = (st_reg == H_IDLE);
  assign bus.addr = addr_reg;
  assign bus.wdata = data_reg;
  assign bus.main_sector_select = sel_reg[N_MAIN-1:0];
  assign bus.secondary_sector_select = sel_reg[N_SECT-1:N_MAIN];
  // every cycle that is not a read is a write strobe
  assign bus.control_pin_zero_n = ~(strobe_reg & write_reg);
  assign bus.rd_n = ~(strobe_reg & ~write_reg);
  assign dev_ready = bus.ready_busy_pin;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= H_IDLE;
      cnt_reg <= 4'h0;
      strobe_reg <= 1'b0;
    end else begin
      case (st_reg)
        H_IDLE: begin
          if (req_valid) begin
            st_reg <= H_SETUP;
            cnt_reg <= 4'(HOST_SETUP_CYC - 1);
          end
        end
        H_SETUP: begin
          // address and selects settle before the strobe falls
          if (cnt_reg == 4'h0) begin
            st_reg <= H_STROBE;
            strobe_reg <= 1'b1;
            cnt_reg <= 4'(HOST_STROBE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        H_STROBE: begin
          if (cnt_reg == 4'h0) begin
            st_reg <= H_HOLD;
            strobe_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        H_HOLD: st_reg <= H_IDLE;
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // request fields held for the whole cycle, data past the rising edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      write_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
      sel_reg <= '0;
    end else if (st_reg == H_IDLE && req_valid) begin
      write_reg <= req_write;
      addr_reg <= req_addr;
      data_reg <= req_data;
      sel_reg <= req_sel;
    end else if (st_reg == H_HOLD) begin
      // selects drop once the strobe has risen, before the next take
      sel_reg <= '0;
    end
  end

  // read data sampled on the last strobe cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resp_valid <= 1'b0;
      resp_data <= '0;
    end else begin
      resp_valid <= (st_reg == H_STROBE) && (cnt_reg == 4'h0);
      if (st_reg == H_STROBE && cnt_reg == 4'h0 && !write_reg) begin
        resp_data <= bus.rdata;
      end
    end
  end
endmodule

// ==== flash_command_sequencer.sv ====
/*
  flash_command_sequencer: decodes write-cycle command sequences for the
  main and secondary flash arrays and times program and erase operations.
  Assumes bus inputs are synchronous to clk_sys and the array itself sits
  on the user-side ports; program and erase algorithms are modelled as fixed
  busy times.
*/
`timescale 1ns/10ps
module flash_command_sequencer import flash_seq_pkg::*; #(
  parameter logic HAS_BYPASS = 1'b1,
  parameter logic [CNT_W-1:0] ERASE_CYC = CNT_W'(ERASE_CYC_DEFAULT),
  parameter logic [7:0] MAIN_ID = MAIN_ID_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  flash_bus_if.device_end bus,
  output logic [ADDR_W-1:0] array_raddr,
  input wire logic [DATA_W-1:0] array_rdata,
  input wire logic [N_SECT-1:0] protect_status,
  output logic prog_start,
  output logic [ADDR_W-1:0] prog_addr,
  output logic [DATA_W-1:0] prog_data,
  output logic [N_SECT-1:0] prog_sel,
  output logic erase_start,
  output logic [N_SECT-1:0] erase_mask,
  output logic erase_suspended,
  output logic bypass_mode
);
  dec_state_t dec_reg, dec_next;
  erase_state_t er_reg;
  logic wr_prev_reg;
  logic [ADDR_W-1:0] addr_lat_reg;
  logic [N_SECT-1:0] sel_lat_reg;
  logic [CNT_W-1:0] gap_cnt_reg, prog_cnt_reg, er_cnt_reg;
  logic prog_busy_reg, bulk_reg, bypass_reg, bypass_next;
  logic wr_fall, wr_rise, cmd_ok, blocked, in_seq;
  logic [7:0] d;
  logic [11:0] a;
  logic [N_SECT-1:0] sel_now;
  logic go_prog, go_sect, add_sect, go_bulk, go_susp, go_resume;
  dec_state_t rest;

  function automatic logic [N_SECT-1:0] array_of(input logic [N_SECT-1:0] s);
    // whole array of whichever array the selects point at
    array_of = (|s[N_MAIN-1:0]) ? {{N_SEC{1'b0}}, {N_MAIN{1'b1}}} :
                                  {{N_SEC{1'b1}}, {N_MAIN{1'b0}}};
  endfunction

  assign sel_now = {bus.secondary_sector_select, bus.main_sector_select};
  assign wr_fall = wr_prev_reg & ~bus.control_pin_zero_n;
  assign wr_rise = ~wr_prev_reg & bus.control_pin_zero_n;
  assign d = bus.wdata;
  assign a = addr_lat_reg[CMD_ADDR_W-1:0];
  assign cmd_ok = wr_rise & (|sel_lat_reg);
  assign blocked = prog_busy_reg | (er_reg == E_WIN) | (er_reg == E_RUN);
  assign rest = bypass_reg ? D_BYP : D_READ;
  assign in_seq = (dec_reg != D_READ) && (dec_reg != D_ID) && (dec_reg != D_BYP);
  assign array_raddr = bus.addr;
  assign erase_suspended = (er_reg == E_SUSP);
  assign bypass_mode = bypass_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_prev_reg <= 1'b1;
      addr_lat_reg <= '0;
      sel_lat_reg <= '0;
    end else begin
      wr_prev_reg <= bus.control_pin_zero_n;
      if (wr_fall) begin
        addr_lat_reg <= bus.addr;
        sel_lat_reg <= sel_now;
      end
    end
  end

  always_comb begin
    dec_next = dec_reg;
    bypass_next = bypass_reg;
    go_prog = 1'b0;
    go_sect = 1'b0;
    add_sect = 1'b0;
    go_bulk = 1'b0;
    go_susp = 1'b0;
    go_resume = 1'b0;
    if (cmd_ok && blocked) begin
      // operation running: only suspend or sector additions count
      if (er_reg == E_RUN && !bulk_reg && d == CMD_SUSPEND) begin
        go_susp = 1'b1;
      end
      if (er_reg == E_WIN && d == CMD_SECTOR) begin
        add_sect = 1'b1;
      end
    end else if (cmd_ok) begin
      // each selected write is decoded; a byte that continues no sequence falls back to rest; D_ID holds except on a reset, an erase resume or a first unlock write
      dec_next = rest;
      if (d == CMD_RESET && dec_reg != D_BYP) begin
        dec_next = rest;
      end else begin
        case (dec_reg)
          D_READ, D_ID: begin
            if (d == CMD_UNLOCK1 && a == UNLOCK_ADDR1) begin
              dec_next = D_U1;
            end else if (er_reg == E_SUSP && d == CMD_SECTOR) begin
              go_resume = 1'b1;
            end else if (dec_reg == D_ID) begin
              dec_next = D_ID;
            end
          end
          D_U1: begin
            if (d == CMD_UNLOCK2 && a == UNLOCK_ADDR2) begin
              dec_next = D_U2;
            end
          end
          D_U2: begin
            if (a == UNLOCK_ADDR1) begin
              case (d)
                CMD_IDENT: dec_next = D_ID;
                CMD_PROGRAM: dec_next = D_PROG;
                CMD_ERASE: dec_next = (er_reg == E_SUSP) ? rest : D_E3;
                CMD_BYPASS: begin
                  if (HAS_BYPASS && er_reg == E_IDLE) begin
                    bypass_next = 1'b1;
                    dec_next = D_BYP;
                  end
                end
                default: dec_next = rest;
              endcase
            end
          end
          D_PROG, D_BYP_PROG: begin
            // while suspended, only sectors outside the erase set
            go_prog = !(er_reg == E_SUSP && |(sel_lat_reg & erase_mask));
          end
          D_E3: begin
            if (d == CMD_UNLOCK1 && a == UNLOCK_ADDR1) begin
              dec_next = D_E4;
            end
          end
          D_E4: begin
            if (d == CMD_UNLOCK2 && a == UNLOCK_ADDR2) begin
              dec_next = D_E5;
            end
          end
          D_E5: begin
            if (d == CMD_SECTOR) begin
              go_sect = 1'b1;
            end else if (d == CMD_BULK && a == UNLOCK_ADDR1) begin
              go_bulk = 1'b1;
            end
          end
          D_BYP: begin
            if (d == CMD_PROGRAM) begin
              dec_next = D_BYP_PROG;
            end else if (d == CMD_IDENT) begin
              dec_next = D_BYP_EXIT;
            end
          end
          D_BYP_EXIT: begin
            if (d == CMD_BYPASS_EXIT) begin
              bypass_next = 1'b0;
              dec_next = D_READ;
            end
          end
          default: dec_next = rest;
        endcase
      end
    end else if (in_seq && gap_cnt_reg == CNT_W'(CMD_GAP_CYC)) begin
      dec_next = rest;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dec_reg <= D_READ;
      bypass_reg <= 1'b0;
    end else begin
      dec_reg <= dec_next;
      bypass_reg <= bypass_next;
    end
  end

  // idle time between command bytes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap_cnt_reg <= '0;
    end else if (wr_rise || !in_seq) begin
      gap_cnt_reg <= '0;
    end else if (gap_cnt_reg != CNT_W'(CMD_GAP_CYC)) begin
      gap_cnt_reg <= gap_cnt_reg + CNT_W'(1);
    end
  end

  // byte program timer; decoder already back in read or bypass mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      prog_start <= 1'b0;
      prog_addr <= '0;
      prog_data <= '0;
      prog_sel <= '0;
    end else begin
      prog_start <= go_prog;
      if (go_prog) begin
        prog_busy_reg <= 1'b1;
        prog_cnt_reg <= CNT_W'(PROG_CYC - 1);
        prog_addr <= addr_lat_reg;
        prog_data <= d;
        prog_sel <= sel_lat_reg;
      end else if (prog_busy_reg) begin
        if (prog_cnt_reg == '0) begin
          prog_busy_reg <= 1'b0;
        end else begin
          prog_cnt_reg <= prog_cnt_reg - CNT_W'(1);
        end
      end
    end
  end

  // erase: addition window, run, suspend; the run count survives a suspend
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      er_reg <= E_IDLE;
      er_cnt_reg <= '0;
      erase_mask <= '0;
      erase_start <= 1'b0;
      bulk_reg <= 1'b0;
    end else begin
      erase_start <= 1'b0;
      case (er_reg)
        E_IDLE: begin
          if (go_sect) begin
            er_reg <= E_WIN;
            erase_mask <= sel_lat_reg;
            er_cnt_reg <= CNT_W'(ERASE_WIN_CYC - 1);
            bulk_reg <= 1'b0;
          end else if (go_bulk) begin
            er_reg <= E_RUN;
            erase_mask <= array_of(sel_lat_reg);
            er_cnt_reg <= ERASE_CYC - CNT_W'(1);
            erase_start <= 1'b1;
            bulk_reg <= 1'b1;
          end
        end
        E_WIN: begin
          if (add_sect) begin
            // each addition reopens the window
            erase_mask <= erase_mask | sel_lat_reg;
            er_cnt_reg <= CNT_W'(ERASE_WIN_CYC - 1);
          end else if (er_cnt_reg == '0) begin
            er_reg <= E_RUN;
            er_cnt_reg <= ERASE_CYC - CNT_W'(1);
            erase_start <= 1'b1;
          end else begin
            er_cnt_reg <= er_cnt_reg - CNT_W'(1);
          end
        end
        E_RUN: begin
          if (go_susp) begin
            er_reg <= E_SUSP;
          end else if (er_cnt_reg == '0) begin
            er_reg <= E_IDLE;
            erase_mask <= '0;
          end else begin
            er_cnt_reg <= er_cnt_reg - CNT_W'(1);
          end
        end
        E_SUSP: begin
          if (go_resume) begin
            er_reg <= E_RUN;
          end
        end
        default: er_reg <= E_IDLE;
      endcase
    end
  end

  // read data path and ready/busy
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus.rdata <= '0;
      bus.ready_busy_pin <= 1'b1;
    end else begin
      bus.ready_busy_pin <= ~(blocked | go_prog | go_sect | go_bulk);
      if (dec_reg == D_ID && bus.addr[1:0] == ID_OFFSET && |bus.main_sector_select) begin
        bus.rdata <= MAIN_ID;
      end else if (dec_reg == D_ID && bus.addr[1:0] == PROT_OFFSET) begin
        bus.rdata <= |(protect_status & sel_now) ? PROT_YES : PROT_NO;
      end else begin
        bus.rdata <= array_rdata;
      end
    end
  end
endmodule

// ==== flash_bus_properties.sv ====
/*
  flash_bus_properties: bus-level checks between host end and sequencer.
  Assumes one clk_sys domain and the host timing of one setup cycle and
  three strobe cycles.
*/
`timescale 1ns/10ps
module flash_bus_properties import flash_seq_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic control_pin_zero_n,
  input wire logic rd_n,
  input wire logic [N_MAIN-1:0] main_sector_select,
  input wire logic [N_SEC-1:0] secondary_sector_select,
  input wire logic ready_busy_pin
);
  logic [3:0] since_wr_reg;

  // saturating, so a long idle never wraps back into the window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      since_wr_reg <= 4'hF;
    end else if (!control_pin_zero_n) begin
      since_wr_reg <= 4'h0;
    end else if (since_wr_reg != 4'hF) begin
      since_wr_reg <= since_wr_reg + 4'h1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  strobe_excl_a: assert property (control_pin_zero_n || rd_n)
    else $error("both strobes low");
  wr_len_a: assert property ($fell(control_pin_zero_n) |->
    (!control_pin_zero_n)[*3] ##1 control_pin_zero_n) else $error("write strobe length");
  rd_len_a: assert property ($fell(rd_n) |-> !rd_n ##1 !rd_n ##1 !rd_n ##1 rd_n)
    else $error("read strobe length");
  wr_addr_hold_a: assert property (!control_pin_zero_n |-> $stable(addr))
    else $error("address moved in strobe");
  wr_data_hold_a: assert property ($fell(control_pin_zero_n) |-> $stable(wdata)[*4])
    else $error("data moved before rise");
  sel_hold_a: assert property ((!control_pin_zero_n || !rd_n) |->
    $stable({secondary_sector_select, main_sector_select})) else $error("select moved");
  sel_release_a: assert property (($rose(control_pin_zero_n) || $rose(rd_n)) |=>
    (main_sector_select == '0 && secondary_sector_select == '0)) else $error("select held");
  strobe_gap_a: assert property (($rose(control_pin_zero_n) || $rose(rd_n)) |->
    (control_pin_zero_n && rd_n)[*3]) else $error("strobes too close");
  busy_start_a: assert property ($fell(ready_busy_pin) |-> since_wr_reg <= 4'h6)
    else $error("busy without command write");

  cover property ($fell(ready_busy_pin));
  cover property ($fell(rd_n) && rdata != 8'h00);
  cover property ($rose(control_pin_zero_n) && wdata == CMD_SUSPEND);
endmodule

// ==== tb.sv ====
/*
  tb: host end and sequencer joined by flash_bus_if, driven from the host
  user port. Assumes array data is address xor 3Ch; erase time shortened.
*/
`timescale 1ns/10ps
module tb import flash_seq_pkg::*;;
  logic clk_sys, rstn, req_valid, req_ready, req_write, resp_valid, dev_ready;
  logic prog_start, erase_start, erase_suspended, bypass_mode;
  logic [15:0] req_addr, array_raddr, prog_addr, wr_addr_seen;
  logic [7:0] req_data, resp_data, array_rdata, prog_data;
  logic [11:0] req_sel, protect_status, prog_sel, erase_mask;
  int bad_count, total_checks, prog_cnt, erase_cnt, busy_cnt;

  flash_bus_if bus_if();
  flash_cmd_host flash_cmd_host_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .req_sel(req_sel),
    .resp_valid(resp_valid), .resp_data(resp_data), .dev_ready(dev_ready));
  flash_command_sequencer #(.ERASE_CYC(24'h000014)) flash_command_sequencer_inst (
    .clk_sys(clk_sys), .rstn(rstn), .bus(bus_if), .array_raddr(array_raddr),
    .array_rdata(array_rdata), .protect_status(protect_status), .prog_start(prog_start),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_sel(prog_sel),
    .erase_start(erase_start), .erase_mask(erase_mask),
    .erase_suspended(erase_suspended), .bypass_mode(bypass_mode));
  flash_bus_properties flash_bus_properties_inst (.clk_sys(clk_sys), .rstn(rstn),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .control_pin_zero_n(bus_if.control_pin_zero_n), .rd_n(bus_if.rd_n),
    .main_sector_select(bus_if.main_sector_select),
    .secondary_sector_select(bus_if.secondary_sector_select),
    .ready_busy_pin(bus_if.ready_busy_pin));

  // address-derived content, so a stored byte would show up as a mismatch
  assign array_rdata = array_raddr[7:0] ^ 8'h3C;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (prog_start === 1'b1) prog_cnt++;
    if (erase_start === 1'b1) erase_cnt++;
    if (dev_ready === 1'b0) busy_cnt++;
  end
  always @(negedge bus_if.control_pin_zero_n) wr_addr_seen = bus_if.addr;

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic [11:0] s, output logic [7:0] q);
    int n;
    @(posedge clk_sys); #1;
    req_valid = 1'b1; req_write = w; req_addr = a; req_data = d; req_sel = s;
    @(posedge clk_sys); #1;
    req_valid = 1'b0;
    chk("req_ready", 16'h0, {15'h0, req_ready});
    n = 0;
    while (resp_valid !== 1'b1) begin
      if (n == 20) begin chk("bus_timeout", 16'h1, 16'h0); end_of_test(); end
      @(posedge clk_sys); #1;
      n++;
    end
    q = resp_data;
  endtask

  // two spare cycles let decoded state land before anyone looks at it
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [11:0] s);
    logic [7:0] q;
    xfer(1'b1, a, d, s, q);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [11:0] s,
                        input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, s, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask

  // high address bits set on purpose: decoding must ignore them
  task automatic unlock(input logic [7:0] c, input logic [11:0] s);
    wr(16'hF555, 8'hAA, s);
    wr(16'h3AAA, 8'h55, s);
    wr(16'h7555, c, s);
  endtask

  task automatic erase_head(input logic [11:0] s);
    unlock(CMD_ERASE, s);
    wr(16'h0555, 8'hAA, s);
    wr(16'h0AAA, 8'h55, s);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (dev_ready !== 1'b1) begin
      if (n == 10000) begin chk("ready_timeout", 16'h1, 16'h0); end_of_test(); end
      @(posedge clk_sys); #1;
      n++;
    end
  endtask

  task automatic wait_erase(input int e0);
    int n;
    n = 0;
    while (erase_cnt == e0) begin
      if (n == 6000) begin chk("erase_timeout", 16'h1, 16'h0); end_of_test(); end
      @(posedge clk_sys); #1;
      n++;
    end
  endtask

  task automatic t_read();
    rd_chk("read_main", 16'h1234, 12'h001, 8'h34 ^ 8'h3C);
    rd_chk("read_sec", 16'h8001, 12'h100, 8'h01 ^ 8'h3C);
  endtask

  task automatic t_ident();
    protect_status = 12'h008;
    unlock(CMD_IDENT, 12'h001);
    rd_chk("ident", 16'h0001, 12'h001, MAIN_ID_DEFAULT);
    rd_chk("prot_yes", 16'hF002, 12'h008, PROT_YES);
    rd_chk("prot_no", 16'h0002, 12'h004, PROT_NO);
    wr(16'h0123, CMD_RESET, 12'h001);
    rd_chk("after_reset", 16'h0001, 12'h001, 8'h01 ^ 8'h3C);
  endtask

  task automatic t_program();
    int p;
    p = prog_cnt;
    unlock(CMD_PROGRAM, 12'h001);
    busy_cnt = 0;
    wr(16'h0123, 8'h5A, 12'h001);
    chk("wr_addr_fall", 16'h0123, wr_addr_seen);
    wait_ready();
    // registered pin trails the program timer by one cycle
    chk("busy_len", 16'(PROG_CYC + 1), 16'(busy_cnt));
    chk("prog_count", 16'(p + 1), 16'(prog_cnt));
    chk("prog_addr", 16'h0123, prog_addr);
    chk("prog_data", 16'h005A, {8'h00, prog_data});
    chk("prog_sel", 16'h0001, {4'h0, prog_sel});
    rd_chk("no_store", 16'h0123, 12'h001, 8'h23 ^ 8'h3C);
  endtask

  task automatic t_bad();
    int p;
    p = prog_cnt;
    unlock(8'h77, 12'h001);
    wr(16'h0555, CMD_PROGRAM, 12'h001);
    wr(16'h0200, 8'h11, 12'h001);
    wr(16'h0555, 8'hAA, 12'h001);
    // gap just past the command timeout
    repeat (4100) @(posedge clk_sys);
    #1;
    wr(16'h0AAA, 8'h55, 12'h001);
    wr(16'h0555, CMD_PROGRAM, 12'h001);
    wr(16'h0200, 8'h11, 12'h001);
    chk("no_prog", 16'(p), 16'(prog_cnt));
  endtask

  task automatic t_sector();
    int e;
    e = erase_cnt;
    wr(16'h0000, CMD_SUSPEND, 12'h001);
    chk("idle_suspend", 16'h0, {15'h0, erase_suspended});
    wr(16'h0000, CMD_SECTOR, 12'h001);
    chk("idle_resume", 16'h1, {15'h0, dev_ready});
    erase_head(12'h002);
    wr(16'h4000, CMD_SECTOR, 12'h002);
    wr(16'h4000, CMD_SECTOR, 12'h100);
    wait_erase(e);
    chk("sector_mask", 16'h0102, {4'h0, erase_mask});
    wr(16'h0000, CMD_SUSPEND, 12'h001);
    chk("suspended", 16'h1, {15'h0, erase_suspended});
    rd_chk("susp_read", 16'h0010, 12'h001, 8'h10 ^ 8'h3C);
    unlock(CMD_IDENT, 12'h001);
    rd_chk("susp_ident", 16'h0001, 12'h001, MAIN_ID_DEFAULT);
    wr(16'h0000, CMD_RESET, 12'h001);
    wr(16'h0000, CMD_SECTOR, 12'h001);
    chk("resumed", 16'h0, {15'h0, erase_suspended});
    wait_ready();
    chk("mask_clear", 16'h0, {4'h0, erase_mask});
  endtask

  task automatic t_bulk();
    int e;
    e = erase_cnt;
    erase_head(12'h010);
    wr(16'h0555, CMD_BULK, 12'h010);
    wait_erase(e);
    chk("bulk_mask", 16'h00FF, {4'h0, erase_mask});
    wait_ready();
  endtask

  task automatic t_bypass();
    int p;
    unlock(CMD_BYPASS, 12'h001);
    chk("bypass_on", 16'h1, {15'h0, bypass_mode});
    p = prog_cnt;
    wr(16'h0777, CMD_PROGRAM, 12'h001);
    wr(16'h0456, 8'h3C, 12'h001);
    wait_ready();
    chk("byp_count", 16'(p + 1), 16'(prog_cnt));
    chk("byp_addr", 16'h0456, prog_addr);
    chk("byp_kept", 16'h1, {15'h0, bypass_mode});
    wr(16'h0000, CMD_RESET, 12'h001);
    chk("byp_reset", 16'h1, {15'h0, bypass_mode});
    wr(16'h0000, CMD_IDENT, 12'h001);
    wr(16'h0000, CMD_BYPASS_EXIT, 12'h001);
    chk("bypass_off", 16'h0, {15'h0, bypass_mode});
  endtask

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_data = 8'h00;
    req_sel = 12'h000;
    protect_status = 12'h000;
    bad_count = 0;
    total_checks = 0;
    prog_cnt = 0;
    erase_cnt = 0;
    busy_cnt = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    chk("ready_reset", 16'h1, {15'h0, dev_ready});
    t_read();
    t_ident();
    t_program();
    t_bad();
    t_sector();
    t_bulk();
    t_bypass();
    end_of_test();
  end
endmodule
